// ==== hdl/level_compare.v ====
// Threshold comparator with enable and one-step hysteresis.
// Assumes capacity and threshold in the same 0.1 % units.
`timescale 1ns/1ps
`default_nettype none
module level_compare #(
    parameter W = 11,
    parameter HYST = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire sample,
    input wire enable,
    input wire [W-1:0] capacity,
    input wire [W-1:0] level,
    output reg active_q
);
    wire [W:0] lower;
    assign lower = {1'b0, level} - HYST[W:0];

    // Set on reaching level, clear below level less hysteresis
    always @(posedge aclk) begin
        if (!aresetn) begin
            active_q <= 1'b0;
        end else if (!enable) begin
            active_q <= 1'b0;
        end else if (sample) begin
            if (capacity >= level)
                active_q <= 1'b1;
            else if (level == {W{1'b0}} || {1'b0, capacity} < lower)
                active_q <= 1'b0;
        end
    end
endmodule // level_compare
`default_nettype wire

// ==== hdl/thermal_stage.v ====
// Output decision logic of the thermal overload stage, AXI4-Lite slave.
// Assumes blocking_in arrives asynchronously from the blocking matrix.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_stage_regs.vh"

// Summary of operation
// - Alarm 1, alarm 2, inhibit and trip each have their own enable, off by default; disabled never drives.
// - Alarm 1 asserts when capacity reaches its level, default 40 percent.
// - Alarm 2 asserts when capacity reaches its level, default 40 percent.
// - Restart inhibit asserts at its level, default 80 percent.
// - Trip condition rises at trip level, default 100 percent.
// - Trip held off by settable delay in 5 ms steps, zero adds none.
// - Blocking input sampled once at start of each program cycle.
// - Pick-up without blocking asserts start and proceeds to timing.
// - Pick-up with blocking asserts blocked and skips further processing.
// - Blocking during start clears start and runs release as pick-up drop.
// - Condition code reported; normal condition drives no output.
// - Load light below 1 percent nominal, normal up to trip limit.
// - Overloading above pick-up up to 2x nominal; high above 2x.
// - Invalid service factor uses 1.0 and flags fault while present.
// - Inconsistent ambient settings use 1.0 and flag fault while present.
// - Behaviour mode on, blocked, test, test blocked or off.
// - Settings change live and apply without restart.
module thermal_stage #(
    parameter CYCLE_CLKS = `TS_CYCLE_CLKS,
    parameter DW = 20
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire blocking_in,
    output reg alarm1_q,
    output reg alarm2_q,
    output reg inhibit_q,
    output reg trip_q,
    output reg start_q,
    output reg blocked_q,
    output reg [2:0] condition_q,
    output reg [1:0] load_q,
    output reg sf_fault_q,
    output reg amb_fault_q
);
    // Settings
    reg [9:0] ctrl_q;
    reg [`TS_PCT_W-1:0] lvl_a1_q, lvl_a2_q, lvl_inh_q, lvl_trip_q;
    reg [DW-1:0] delay_q;
    reg [`TS_PCT_W-1:0] capacity_q;
    reg [15:0] current_q;
    // Bus state
    reg [7:0] awaddr_q;
    reg aw_held_q, w_held_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    // Program cycle and blocking
    reg [31:0] cyc_cnt_q;
    reg tick_q;
    reg blk_meta_q, blk_sync_q, blk_smp_q;
    reg [DW-1:0] dly_cnt_q;
    reg trip_timed_q;

    wire [2:0] mode;
    wire test_mode, mode_block, mode_off;
    wire a1_raw, a2_raw, inh_raw, trip_raw;
    wire blocked_now, pickup;

    // Map a byte lane strobe onto a word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Known register offset check
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `TS_FAULT_OFS);
        end
    endfunction

    assign mode = ctrl_q[`TS_MODE_MSB:`TS_MODE_LSB];
    assign mode_off = (mode == `TS_MODE_OFF) || (mode > `TS_MODE_OFF);
    assign mode_block = (mode == `TS_MODE_BLK) || (mode == `TS_MODE_TESTBLK);
    assign test_mode = (mode == `TS_MODE_TEST) || (mode == `TS_MODE_TESTBLK);

    // Byte-lane merge of each writable register with the held write word
    wire [31:0] m_ctrl, m_a1, m_a2, m_inh, m_trip, m_dly, m_cap, m_cur;
    assign m_ctrl = merge({22'h000000, ctrl_q}, wdata_q, wstrb_q);
    assign m_a1 = merge({21'h000000, lvl_a1_q}, wdata_q, wstrb_q);
    assign m_a2 = merge({21'h000000, lvl_a2_q}, wdata_q, wstrb_q);
    assign m_inh = merge({21'h000000, lvl_inh_q}, wdata_q, wstrb_q);
    assign m_trip = merge({21'h000000, lvl_trip_q}, wdata_q, wstrb_q);
    assign m_dly = merge({12'h000, delay_q}, wdata_q, wstrb_q);
    assign m_cap = merge({21'h000000, capacity_q}, wdata_q, wstrb_q);
    assign m_cur = merge({16'h0000, current_q}, wdata_q, wstrb_q);

    // Threshold comparators, enables applied live
    level_compare #(.W(`TS_PCT_W), .HYST(1)) u_a1 (
        .aclk(aclk), .aresetn(aresetn), .sample(tick_q),
        .enable(ctrl_q[`TS_EN_ALARM1_BIT] & ~mode_off),
        .capacity(capacity_q), .level(lvl_a1_q), .active_q(a1_raw));
    level_compare #(.W(`TS_PCT_W), .HYST(1)) u_a2 (
        .aclk(aclk), .aresetn(aresetn), .sample(tick_q),
        .enable(ctrl_q[`TS_EN_ALARM2_BIT] & ~mode_off),
        .capacity(capacity_q), .level(lvl_a2_q), .active_q(a2_raw));
    level_compare #(.W(`TS_PCT_W), .HYST(1)) u_inh (
        .aclk(aclk), .aresetn(aresetn), .sample(tick_q),
        .enable(ctrl_q[`TS_EN_INHIBIT_BIT] & ~mode_off),
        .capacity(capacity_q), .level(lvl_inh_q), .active_q(inh_raw));
    level_compare #(.W(`TS_PCT_W), .HYST(1)) u_trip (
        .aclk(aclk), .aresetn(aresetn), .sample(tick_q),
        .enable(ctrl_q[`TS_EN_TRIP_BIT] & ~mode_off),
        .capacity(capacity_q), .level(lvl_trip_q), .active_q(trip_raw));

    assign pickup = trip_raw;
    assign blocked_now = blk_smp_q | mode_block;

    // Program cycle tick, 5 ms
    always @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (cyc_cnt_q >= CYCLE_CLKS - 1) begin
            cyc_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            cyc_cnt_q <= cyc_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // Blocking synchroniser, sampled on the clock before each tick
    always @(posedge aclk) begin
        if (!aresetn) begin
            blk_meta_q <= 1'b0;
            blk_sync_q <= 1'b0;
            blk_smp_q <= 1'b0;
        end else begin
            blk_meta_q <= blocking_in;
            blk_sync_q <= blk_meta_q;
            if (cyc_cnt_q >= CYCLE_CLKS - 1)
                blk_smp_q <= blk_sync_q;
        end
    end

    // Start, blocked and trip delay
    always @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
            blocked_q <= 1'b0;
            dly_cnt_q <= {DW{1'b0}};
            trip_timed_q <= 1'b0;
        end else if (!pickup) begin
            start_q <= 1'b0;
            blocked_q <= 1'b0;
            dly_cnt_q <= {DW{1'b0}};
            trip_timed_q <= 1'b0;
        end else if (tick_q) begin
            if (blocked_now) begin
                blocked_q <= 1'b1;
                start_q <= 1'b0;
                dly_cnt_q <= {DW{1'b0}};
                trip_timed_q <= 1'b0;
            end else begin
                blocked_q <= 1'b0;
                start_q <= 1'b1;
                if (dly_cnt_q >= delay_q) begin
                    trip_timed_q <= 1'b1;
                end else begin
                    dly_cnt_q <= dly_cnt_q + {{(DW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Outputs; test mode keeps the I/O quiet, blocking quiets only trip via start_q
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm1_q <= 1'b0;
            alarm2_q <= 1'b0;
            inhibit_q <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            alarm1_q <= a1_raw & ~test_mode;
            alarm2_q <= a2_raw & ~test_mode;
            inhibit_q <= inh_raw & ~test_mode;
            trip_q <= trip_timed_q & start_q & ~test_mode;
        end
    end

    // Condition code, highest severity first
    always @(posedge aclk) begin
        if (!aresetn)
            condition_q <= `TS_COND_NORMAL;
        else if (blocked_q)
            condition_q <= `TS_COND_BLOCKED;
        else if (trip_timed_q & start_q)
            condition_q <= `TS_COND_TRIP;
        else if (inh_raw)
            condition_q <= `TS_COND_INHIBIT;
        else if (a2_raw)
            condition_q <= `TS_COND_ALARM2;
        else if (a1_raw)
            condition_q <= `TS_COND_ALARM1;
        else
            condition_q <= `TS_COND_NORMAL;
    end

    // Load classification from current in 0.1 % of nominal
    always @(posedge aclk) begin
        if (!aresetn)
            load_q <= `TS_LOAD_LIGHT;
        else if (current_q < `TS_CUR_LIGHT)
            load_q <= `TS_LOAD_LIGHT;
        else if (current_q > `TS_CUR_HIGH)
            load_q <= `TS_LOAD_HIGH;
        else if (current_q > {5'h00, lvl_trip_q})
            load_q <= `TS_LOAD_OVER;
        else
            load_q <= `TS_LOAD_NORMAL;
    end

    // Setting faults follow their inputs, shown only while present
    always @(posedge aclk) begin
        if (!aresetn) begin
            sf_fault_q <= 1'b0;
            amb_fault_q <= 1'b0;
        end else begin
            sf_fault_q <= ctrl_q[`TS_SF_BAD_BIT];
            amb_fault_q <= ctrl_q[`TS_AMB_BAD_BIT];
        end
    end

    // AXI write: hold address and data until both present
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_held_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? 2'b00 : 2'b10;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes take effect at once, no restart
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TS_CTRL_RST;
            lvl_a1_q <= `TS_ALARM1_RST;
            lvl_a2_q <= `TS_ALARM2_RST;
            lvl_inh_q <= `TS_INHIBIT_RST;
            lvl_trip_q <= `TS_TRIP_RST;
            delay_q <= `TS_DELAY_RST;
            capacity_q <= {`TS_PCT_W{1'b0}};
            current_q <= 16'h0000;
        end else if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            case (awaddr_q)
                `TS_CTRL_OFS: ctrl_q <= m_ctrl[9:0];
                `TS_ALARM1_OFS: lvl_a1_q <= m_a1[`TS_PCT_W-1:0];
                `TS_ALARM2_OFS: lvl_a2_q <= m_a2[`TS_PCT_W-1:0];
                `TS_INHIBIT_OFS: lvl_inh_q <= m_inh[`TS_PCT_W-1:0];
                `TS_TRIP_OFS: lvl_trip_q <= m_trip[`TS_PCT_W-1:0];
                `TS_DELAY_OFS: delay_q <= m_dly[DW-1:0];
                `TS_CAPACITY_OFS: capacity_q <= m_cap[`TS_PCT_W-1:0];
                `TS_CURRENT_OFS: current_q <= m_cur[15:0];
                default: ;
            endcase
        end
    end

    // AXI read, one word per request
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                `TS_CTRL_OFS: s_axi_rdata <= {22'h000000, ctrl_q};
                `TS_ALARM1_OFS: s_axi_rdata <= {21'h000000, lvl_a1_q};
                `TS_ALARM2_OFS: s_axi_rdata <= {21'h000000, lvl_a2_q};
                `TS_INHIBIT_OFS: s_axi_rdata <= {21'h000000, lvl_inh_q};
                `TS_TRIP_OFS: s_axi_rdata <= {21'h000000, lvl_trip_q};
                `TS_DELAY_OFS: s_axi_rdata <= {12'h000, delay_q};
                `TS_CAPACITY_OFS: s_axi_rdata <= {21'h000000, capacity_q};
                `TS_CURRENT_OFS: s_axi_rdata <= {16'h0000, current_q};
                `TS_STATUS_OFS:
                    s_axi_rdata <= {16'h0000, 2'b00, blocked_q, start_q,
                                    trip_q, inhibit_q, alarm2_q, alarm1_q,
                                    1'b0, condition_q, 2'b00, load_q};
                `TS_FAULT_OFS:
                    s_axi_rdata <= {30'h00000000, amb_fault_q, sf_fault_q};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // thermal_stage
`default_nettype wire

// ==== include/thermal_stage_regs.vh ====
// Register map, field positions, reset values and timing for thermal_stage.
// Assumes a 100 MHz aclk and 32-bit AXI4-Lite access.
`ifndef THERMAL_STAGE_REGS_VH
`define THERMAL_STAGE_REGS_VH

// Byte offsets
`define TS_CTRL_OFS      8'h00
`define TS_ALARM1_OFS    8'h04
`define TS_ALARM2_OFS    8'h08
`define TS_INHIBIT_OFS   8'h0C
`define TS_TRIP_OFS      8'h10
`define TS_DELAY_OFS     8'h14
`define TS_CAPACITY_OFS  8'h18
`define TS_CURRENT_OFS   8'h1C
`define TS_STATUS_OFS    8'h20
`define TS_FAULT_OFS     8'h24

// Control field positions
`define TS_EN_ALARM1_BIT  0
`define TS_EN_ALARM2_BIT  1
`define TS_EN_INHIBIT_BIT 2
`define TS_EN_TRIP_BIT    3
`define TS_MODE_LSB       4
`define TS_MODE_MSB       6
`define TS_SF_BAD_BIT     8
`define TS_AMB_BAD_BIT    9

// Reset values, thresholds in 0.1 % units
`define TS_CTRL_RST      10'h000
`define TS_ALARM1_RST    11'h190
`define TS_ALARM2_RST    11'h190
`define TS_INHIBIT_RST   11'h320
`define TS_TRIP_RST      11'h3E8
`define TS_DELAY_RST     20'h00000
`define TS_PCT_W         11

// Behaviour modes
`define TS_MODE_ON       3'h0
`define TS_MODE_BLK      3'h1
`define TS_MODE_TEST     3'h2
`define TS_MODE_TESTBLK  3'h3
`define TS_MODE_OFF      3'h4

// Operating condition codes
`define TS_COND_NORMAL   3'h0
`define TS_COND_ALARM1   3'h1
`define TS_COND_ALARM2   3'h2
`define TS_COND_INHIBIT  3'h3
`define TS_COND_TRIP     3'h4
`define TS_COND_BLOCKED  3'h5

// Load status codes
`define TS_LOAD_LIGHT    2'h0
`define TS_LOAD_NORMAL   2'h1
`define TS_LOAD_OVER     2'h2
`define TS_LOAD_HIGH     2'h3

// Current in 0.1 % of nominal: 1 % and 2 x nominal
`define TS_CUR_LIGHT     16'h000A
`define TS_CUR_HIGH      16'h07D0

// Program cycle and trip delay step
`define TS_CLK_NS        10
`define TS_CYCLE_NS      5000000
`define TS_CYCLE_CLKS    (`TS_CYCLE_NS / `TS_CLK_NS)

`endif

// ==== verification/block_source.sv ====
// Blocking matrix model driving the stage's block input.
// Assumes the bench asks for blocking by a level on block_req.
`timescale 1ns/1ps
`default_nettype none
module block_source (
    input wire logic aclk,
    input wire logic block_req,
    output var logic blocking_in
);
    // Block level launched after the edge, idle low
    initial blocking_in = 1'b0;
    always @(posedge aclk) begin
        blocking_in <= block_req;
    end
endmodule // block_source
`default_nettype wire

// ==== verification/thermal_stage_properties.sv ====
// Checker for the thermal_stage outputs and AXI answer timing.
// Assumes binding to thermal_stage with CYCLE_CLKS handed on.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_stage_regs.vh"
module thermal_stage_props #(
    parameter CYCLE_CLKS = 10
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire blocking_in,
    input wire alarm1_q,
    input wire alarm2_q,
    input wire inhibit_q,
    input wire trip_q,
    input wire start_q,
    input wire blocked_q,
    input wire [2:0] condition_q
);
    localparam int BLK_MAX = 2 * CYCLE_CLKS + 4;
    reg [31:0] blk_cnt_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles that start stays up under blocking
    always @(posedge aclk) begin
        if (!aresetn || !(start_q && blocking_in)) blk_cnt_q <= 32'h0;
        else blk_cnt_q <= blk_cnt_q + 32'h1;
    end
    property p_cond_normal;
        condition_q == `TS_COND_NORMAL
            |-> !(alarm1_q || alarm2_q || inhibit_q || trip_q);
    endproperty
    property p_start_excl;
        !(start_q && blocked_q);
    endproperty
    property p_trip_start;
        $rose(trip_q) |-> $past(start_q);
    endproperty
    property p_block_clear;
        blk_cnt_q < BLK_MAX;
    endproperty
    property p_reset_clear;
        @(posedge aclk) $rose(aresetn) |-> !(trip_q || start_q || blocked_q
            || alarm1_q || alarm2_q || inhibit_q);
    endproperty
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> ##1 s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_cond_normal: assert property (p_cond_normal)
        else $error("output driven in normal condition");
    a_start_excl: assert property (p_start_excl)
        else $error("start and blocked high together");
    a_trip_start: assert property (p_trip_start)
        else $error("trip rose without start");
    a_block_clear: assert property (p_block_clear)
        else $error("start not cleared by blocking");
    a_reset_clear: assert property (p_reset_clear)
        else $error("output high after reset");
    a_b_answer: assert property (p_b_answer)
        else $error("write response late");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_answer: assert property (p_r_answer)
        else $error("read data late");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    c_trip: cover property ($rose(trip_q));
    c_blocked: cover property (blocked_q);
    c_start: cover property (start_q && !trip_q);
endmodule // thermal_stage_props
bind thermal_stage thermal_stage_props #(.CYCLE_CLKS(CYCLE_CLKS))
    u_thermal_stage_props (.*);
`default_nettype wire

// ==== verification/thermal_stage_tb.sv ====
// Testbench for thermal_stage: AXI4-Lite settings, output levels.
// Assumes a short program cycle of CYC clocks for simulation.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_stage_regs.vh"
module thermal_stage_tb;
    localparam int CYC = 10;
    logic aclk = 1'b0, aresetn = 1'b0, block_req = 1'b0, blocking_in;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, alarm1_q, alarm2_q, inhibit_q, trip_q, start_q;
    logic blocked_q, sf_fault_q, amb_fault_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, load_q;
    logic [2:0] condition_q;
    int failures = 0, tests_run = 0;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rst [6] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8, 32'h0};
    logic [15:0] cur [5] = '{16'h0009, 16'h000A, 16'h03E9, 16'h07D0, 16'h07D1};
    logic [1:0] ld [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    thermal_stage #(.CYCLE_CLKS(CYC)) u_thermal_stage (.*);
    block_source u_block_source (.*);
    // Clock at 100 MHz
    always #5 aclk = ~aclk;
    task automatic summarize;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) failures++;
        if (n >= 100) summarize();
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) failures++;
        if (n >= 100) summarize();
    endtask
    task automatic tick(input int n);
        repeat (n * CYC) @(posedge aclk);
    endtask
    task automatic outs(input logic [3:0] e);
        check({trip_q, inhibit_q, alarm2_q, alarm1_q}, e);
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (60000) @(posedge aclk);
        failures++;
        summarize();
    end
    // Main sequence
    initial begin
        int i, n;
        logic [31:0] d;
        logic [1:0] r;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(ofs[i], d, r);
            check(d, rst[i]);
        end
        rd(8'h30, d, r);
        check(r, 2'h2);
        check(d, 32'h0);
        wr(8'h30, 32'h1, 2'h2);
        // Disabled outputs stay quiet at full capacity
        wr(`TS_CAPACITY_OFS, 32'h3E8);
        tick(4);
        outs(4'h0);
        check(condition_q, `TS_COND_NORMAL);
        // Threshold edges with all outputs enabled
        wr(`TS_CAPACITY_OFS, 32'h18F);
        wr(`TS_CTRL_OFS, 32'hF);
        tick(3);
        outs(4'h0);
        wr(`TS_CAPACITY_OFS, 32'h190);
        tick(3);
        outs(4'h3);
        check(condition_q, `TS_COND_ALARM2);
        wr(`TS_CAPACITY_OFS, 32'h320);
        tick(3);
        outs(4'h7);
        check(condition_q, `TS_COND_INHIBIT);
        wr(`TS_CAPACITY_OFS, 32'h3E8);
        tick(4);
        outs(4'hF);
        check(condition_q, `TS_COND_TRIP);
        check(start_q, 1'b1);
        wr(`TS_CAPACITY_OFS, 32'h100);
        tick(3);
        outs(4'h0);
        // Trip level lowered live
        wr(`TS_TRIP_OFS, 32'h0C8);
        tick(4);
        check(trip_q, 1'b1);
        wr(`TS_TRIP_OFS, 32'h3E8);
        wr(`TS_DELAY_OFS, 32'h3);
        tick(3);
        // Delayed trip counted from start
        wr(`TS_CAPACITY_OFS, 32'h3E8);
        n = 0;
        while (start_q !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        check(n < 100, 1'b1);
        repeat (3 * CYC - 1) @(posedge aclk);
        check(trip_q, 1'b0);
        repeat (CYC + 3) @(posedge aclk);
        check(trip_q, 1'b1);
        wr(`TS_CTRL_OFS, 32'h7);
        tick(2);
        check(trip_q, 1'b0);
        wr(`TS_CTRL_OFS, 32'hF);
        tick(2);
        check(trip_q, 1'b0);
        // Blocking while start is active
        block_req <= 1'b1;
        tick(3);
        check({start_q, blocked_q, trip_q}, 3'b010);
        check(condition_q, `TS_COND_BLOCKED);
        block_req <= 1'b0;
        tick(3);
        check({start_q, blocked_q}, 2'b10);
        // Behaviour modes
        wr(`TS_DELAY_OFS, 32'h0);
        for (i = 0; i < 5; i++) begin
            wr(`TS_CTRL_OFS, {25'h0, i[2:0], 4'hF});
            tick(4);
            check(trip_q, i == 0);
            if (i != 1) check(alarm1_q, i == 0);
        end
        // Load classification
        for (i = 0; i < 5; i++) begin
            wr(`TS_CURRENT_OFS, {16'h0, cur[i]});
            tick(2);
            check(load_q, ld[i]);
        end
        // Setting fault flags
        wr(`TS_CTRL_OFS, 32'h10F);
        tick(1);
        check({sf_fault_q, amb_fault_q}, 2'b10);
        wr(`TS_CTRL_OFS, 32'h20F);
        tick(1);
        check({sf_fault_q, amb_fault_q}, 2'b01);
        summarize();
    end
endmodule // thermal_stage_tb
`default_nettype wire
